// ==== design/srwd_consts.vh ====
// Timing constants for the supervisor reset and watchdog core.
// Assumes a 100 MHz timebase clock; included by the core module only.
`ifndef SRWD_CONSTS_VH
`define SRWD_CONSTS_VH

// Timebase clock rate in hertz.
`define SRWD_CLK_HZ          100000000
// Reset stretch time in milliseconds.
`define SRWD_STRETCH_MS      200
// Watchdog timeout in tenths of a second (1.6 s).
`define SRWD_TIMEOUT_DS      16
// Stretch count in cycles, 200 ms at the clock rate, sized to the counter.
`define SRWD_STRETCH_CYC     28'h1312D00
// Timeout count in cycles, 1.6 s at the clock rate, sized to the counter.
`define SRWD_TIMEOUT_CYC     28'h9896800
// Counter width, wide enough for both counts.
`define SRWD_CNT_W           28

`endif

// ==== design/srwd_core.v ====
// Digital core of a processor supervisor: stretched reset and watchdog.
// Assumes the pin inputs are asynchronous levels and rst is synchronous; the pad logic reports a floating
// kick input on a separate level input.
`timescale 1ns/1ps
`include "srwd_consts.vh"

module srwd_core #(
  parameter [`SRWD_CNT_W-1:0] STRETCH_CYCLES = `SRWD_STRETCH_CYC,
  parameter [`SRWD_CNT_W-1:0] TIMEOUT_CYCLES = `SRWD_TIMEOUT_CYC
) (
  input  wire mclk,
  input  wire rst,
  input  wire undervoltage_in,
  input  wire manual_reset_n_in,
  input  wire watchdog_kick_in,
  input  wire kick_floating_in,
  output reg  reset_n,
  output wire reset_hi,
  output reg  watchdog_fault_n
);

  // Two-stage synchronisers. Stage one is read only by stage two, so a
  // metastable first flop can never reach the counting logic.
  reg                   uv_s1;
  reg                   uv_s2;
  reg                   mr_s1;
  reg                   mr_s2;
  reg                   kick_s1;
  reg                   kick_s2;
  reg                   kick_prev;
  reg                   flt_s1;
  reg                   flt_s2;

  // Stretch counter, watchdog counter and the latched expiry flag.
  reg [`SRWD_CNT_W-1:0] stretch_cnt;
  reg [`SRWD_CNT_W-1:0] wd_cnt;
  reg                   wd_expired;

  // Next values, worked out by the combinational processes below.
  reg [`SRWD_CNT_W-1:0] next_stretch_cnt;
  reg                   next_reset_n;
  reg [`SRWD_CNT_W-1:0] next_wd_cnt;
  reg                   next_wd_expired;
  reg                   next_watchdog_fault_n;

  // Decoded conditions shared by several processes.
  wire                  reset_source;
  wire                  kick_edge;
  wire                  wd_clear;
  wire                  wd_at_limit;
  wire                  stretch_busy;

  // The stretch keeps counting down while the count is at least two; the
  // last step releases reset, so the low time is STRETCH_CYCLES edges.
  localparam [`SRWD_CNT_W-1:0] STRETCH_LAST = {{(`SRWD_CNT_W-2){1'b0}}, 2'b10};
  // The expiry flag sets on the edge after the counter reaches this value.
  localparam [`SRWD_CNT_W-1:0] TIMEOUT_LAST = TIMEOUT_CYCLES - 1'b1;

  // Compares a count against a bound; shared by both timers so that their
  // end points are decided in one place.
  function srwd_at_least;
    input [`SRWD_CNT_W-1:0] value;
    input [`SRWD_CNT_W-1:0] bound;
    begin
      srwd_at_least = (value >= bound);
    end
  endfunction

  // Steps a counter down by one and stops at zero, so it never wraps
  // around into a huge stretch if it is ever reached at zero.
  function [`SRWD_CNT_W-1:0] srwd_count_down;
    input [`SRWD_CNT_W-1:0] value;
    begin
      if (value == {`SRWD_CNT_W{1'b0}}) begin
        srwd_count_down = value;
      end else begin
        srwd_count_down = value - 1'b1;
      end
    end
  endfunction

  // Steps a counter up by one and holds it at the top value, so a very
  // long idle span cannot wrap the watchdog back into its quiet range.
  function [`SRWD_CNT_W-1:0] srwd_count_up;
    input [`SRWD_CNT_W-1:0] value;
    begin
      if (value == {`SRWD_CNT_W{1'b1}}) begin
        srwd_count_up = value;
      end else begin
        srwd_count_up = value + 1'b1;
      end
    end
  endfunction

  // Synchronise all pin levels to the timebase clock.
  // The undervoltage and floating stages start high, so the core comes out
  // of reset as if the supply had just risen and the kick pin were open.
  always @(posedge mclk) begin
    if (rst) begin
      uv_s1     <= 1'b1;
      uv_s2     <= 1'b1;
      mr_s1     <= 1'b1;
      mr_s2     <= 1'b1;
      kick_s1   <= 1'b0;
      kick_s2   <= 1'b0;
      kick_prev <= 1'b0;
      flt_s1    <= 1'b1;
      flt_s2    <= 1'b1;
    end else begin
      uv_s1     <= undervoltage_in;
      uv_s2     <= uv_s1;
      mr_s1     <= manual_reset_n_in;
      mr_s2     <= mr_s1;
      kick_s1   <= watchdog_kick_in;
      kick_s2   <= kick_s1;
      kick_prev <= kick_s2;
      flt_s1    <= kick_floating_in;
      flt_s2    <= flt_s1;
    end
  end

  // Watchdog expiry plays no part here, so a timeout never resets by itself.
  // A user who wants a reset on timeout wires the fault pin to manual reset.
  assign reset_source = uv_s2 | ~mr_s2;
  // Both edge directions count alike; the history flop sits after stage two.
  assign kick_edge    = kick_s2 ^ kick_prev;
  // Reset, an open kick pin or a kick edge all clear the watchdog timer.
  assign wd_clear     = ~reset_n | flt_s2 | kick_edge;
  assign wd_at_limit  = srwd_at_least(wd_cnt, TIMEOUT_LAST);
  assign stretch_busy = srwd_at_least(stretch_cnt, STRETCH_LAST);

  // Reset stretch: reload while a source is active, count down afterwards.
  // Bounce on the manual input just reloads the count, giving one pulse;
  // the cost is that the pulse ends a full stretch after the last bounce.
  always @* begin
    next_stretch_cnt = stretch_cnt;
    next_reset_n     = reset_n;
    if (reset_source) begin
      next_stretch_cnt = STRETCH_CYCLES;
      next_reset_n     = 1'b0;
    end else if (stretch_busy) begin
      next_stretch_cnt = srwd_count_down(stretch_cnt);
      next_reset_n     = 1'b0;
    end else begin
      next_stretch_cnt = {`SRWD_CNT_W{1'b0}};
      next_reset_n     = 1'b1;
    end
  end

  // Stretch registers; the core reset behaves like a fresh power-up.
  always @(posedge mclk) begin
    if (rst) begin
      stretch_cnt <= STRETCH_CYCLES;
      reset_n     <= 1'b0;
    end else begin
      stretch_cnt <= next_stretch_cnt;
      reset_n     <= next_reset_n;
    end
  end

  // Both polarities come from the same flop, so they can never disagree.
  assign reset_hi = ~reset_n;

  // Watchdog timer; expiry latches until an edge, reset, or floating input.
  // A clear in the same cycle as the expiry wins, since the kick came in time.
  always @* begin
    next_wd_cnt     = wd_cnt;
    next_wd_expired = wd_expired;
    if (wd_clear) begin
      next_wd_cnt     = {`SRWD_CNT_W{1'b0}};
      next_wd_expired = 1'b0;
    end else if (wd_at_limit) begin
      next_wd_expired = 1'b1;
    end else begin
      next_wd_cnt     = srwd_count_up(wd_cnt);
    end
  end

  // Watchdog registers.
  always @(posedge mclk) begin
    if (rst) begin
      wd_cnt     <= {`SRWD_CNT_W{1'b0}};
      wd_expired <= 1'b0;
    end else begin
      wd_cnt     <= next_wd_cnt;
      wd_expired <= next_wd_expired;
    end
  end

  // Undervoltage low-line overrides the timer and releases with no stretch.
  // With the kick pin open the expiry flag stays clear, leaving a low-line flag.
  always @* begin
    next_watchdog_fault_n = ~(uv_s2 | wd_expired);
  end

  // Fault output register; it resets high, then goes low for two cycles while the undervoltage stages still hold their reset value.
  always @(posedge mclk) begin
    if (rst) begin
      watchdog_fault_n <= 1'b1;
    end else begin
      watchdog_fault_n <= next_watchdog_fault_n;
    end
  end

endmodule // srwd_core

// ==== verification/srwd_chk.sv ====
// Checker on the supervisor core ports.
// Assumes it is bound into srwd_core and takes its counts.
`timescale 1ns/1ps
module srwd_chk #(parameter STRETCH_CYCLES = 20, parameter TIMEOUT_CYCLES = 50) (
  input wire logic mclk, rst, undervoltage_in, manual_reset_n_in, watchdog_kick_in,
  input wire logic kick_floating_in, reset_n, reset_hi, watchdog_fault_n);
  int q, k;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Spans free of reset sources and of kick edges; margins cover the synchronisers.
  always @(posedge mclk) begin
    q <= (rst || undervoltage_in || !manual_reset_n_in) ? 0 : q + 1;
    k <= (rst || !reset_n || kick_floating_in || watchdog_kick_in != $past(watchdog_kick_in)) ? 0 : k + 1;
  end
  chk_hi_inv: assert property (reset_hi == !reset_n) else $error("inverse lost");
  chk_uv_hold: assert property (
    undervoltage_in[*5] |-> !reset_n && !watchdog_fault_n) else $error("supply low ignored");
  chk_mr_hold: assert property (!manual_reset_n_in[*5] |-> !reset_n) else $error("manual");
  chk_min_stretch: assert property (
    $rose(reset_n) |-> q >= STRETCH_CYCLES) else $error("stretch short");
  chk_no_wd_reset: assert property (
    q > STRETCH_CYCLES + 6 |-> reset_n) else $error("stretch long");
  chk_wd_expire: assert property (
    k > TIMEOUT_CYCLES + 6 |-> !watchdog_fault_n) else $error("late fault");
  chk_wd_quiet: assert property (
    !undervoltage_in[*4] ##0 (k > 6 && k < TIMEOUT_CYCLES) |-> watchdog_fault_n)
    else $error("early fault");
  chk_uv_release: assert property (
    $fell(undervoltage_in) |-> ##[1:6] watchdog_fault_n) else $error("fault held");
endmodule // srwd_chk
bind srwd_core srwd_chk #(.STRETCH_CYCLES(STRETCH_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) srwd_chk_inst (.*);

// ==== verification/srwd_host.sv ====
// Host model: toggles the kick line every gap+1 cycles; a gap of zero stalls it.
// Assumes mclk is the core's timebase clock.
`timescale 1ns/1ps
module srwd_host (
  input  wire logic       mclk,
  input  wire logic [7:0] gap,
  output logic            kick = 1'b0);
  int n = 0;
  // Short gaps keep kicks well inside the timeout.
  always @(posedge mclk) begin
    n <= (gap != 0 && n >= gap) ? 0 : n + 1;
    if (gap != 0 && n >= gap) kick <= #1 ~kick;
  end
endmodule // srwd_host

// ==== verification/tb_top.sv ====
// Bench for srwd_core: a table of supply, manual reset and kick phases.
// Assumes srwd_host and the bound srwd_chk are compiled before it.
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, rst = 1, uv = 0, mr = 1, fl = 0;
  logic [7:0] gap = 8'h0A;
  wire kick, rn, rh, wf;
  int error_cnt = 0, checks = 0, seed = 32'h01CB;
  // Row: uv mr fl, expected reset_n and fault_n, kick gap, cycles to wait.
  logic [23:0] tab [12] = '{24'h410A04, 24'h430A28, 24'h42003C, 24'h43050C,
    24'h010506, 24'h41050A, 24'h430514, 24'hC00506,
    24'h410506, 24'h630050, 24'hE00006, 24'h610006};
  always #5 mclk = ~mclk;
  srwd_host srwd_host_inst (.mclk(mclk), .gap(gap), .kick(kick));
  srwd_core #(.STRETCH_CYCLES(28'h14), .TIMEOUT_CYCLES(28'h32)) srwd_core_inst (.mclk(mclk),
    .rst(rst), .undervoltage_in(uv), .manual_reset_n_in(mr), .watchdog_kick_in(kick),
    .kick_floating_in(fl), .reset_n(rn), .reset_hi(rh), .watchdog_fault_n(wf));
  task cmp(string s, logic seen, logic exp);
    checks++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("Error %s expected %b seen %b", s, exp, seen);
  endtask
  task finish_test;
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ends 1 ns past the edge so drives never race the sampling.
  task run(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    run(600);
    error_cnt++;
    finish_test;
  end
  // Manual reset rows first bounce the line at random.
  initial begin
    run(16);
    rst = 0;
    foreach (tab[i]) begin
      if (!tab[i][22]) repeat (6) begin
        mr = 1'($random(seed));
        run(1);
      end
      {uv, mr, fl} = tab[i][23:21];
      gap = tab[i][15:8];
      run(tab[i][7:0]);
      cmp("reset_n", rn, tab[i][17]);
      cmp("reset_hi", rh, !tab[i][17]);
      cmp("fault_n", wf, tab[i][16]);
    end
    finish_test;
  end
endmodule // tb_top
